// [inc/decode_pkg.sv]
package decode_pkg;

	// ---------------------------------------------------------------
	// Word layout
	// ---------------------------------------------------------------
	localparam int WORD_W      = 16;
	localparam int FILE_W      = 8;
	localparam int LONG_FILE_W = 12;
	localparam int BIT_W       = 3;
	localparam int LIT8_W      = 8;
	localparam int LIT12_W     = 12;
	localparam int LIT20_W     = 20;
	localparam int PTR_W       = 21;
	localparam int BRANCH_W    = 11;
	localparam int MODE_W      = 2;

	localparam int FILE_LSB    = 0;
	localparam int ACCESS_BIT  = 8;
	localparam int DEST_BIT    = 9;
	localparam int BITNUM_LSB  = 9;
	localparam int LONG_LSB    = 0;
	localparam int TOP_LSB     = 12;
	localparam int LIT_LSB     = 0;
	localparam int FAST_BIT    = 0;
	localparam int MODE_LSB    = 0;

	// ---------------------------------------------------------------
	// Opcode classes (upper nibble or upper bits)
	// ---------------------------------------------------------------
	localparam logic [3:0] TOP_SECOND  = 4'hF; // second-word marker
	localparam logic [3:0] TOP_MOVE    = 4'hC; // register move
	localparam logic [3:0] TOP_BRA     = 4'hD; // relative branch/call
	localparam logic [3:0] TOP_CTRL    = 4'hE; // absolute / conditional
	localparam logic [3:0] TOP_LIT     = 4'h0; // literal and misc group
	localparam logic [3:0] TOP_BIT_LO  = 4'h7; // bit ops 0x7..0xB
	localparam logic [3:0] TOP_BIT_HI  = 4'hB;
	localparam logic [7:0] HI_GOTO     = 8'hEF;
	localparam logic [7:0] HI_CALL0    = 8'hEC;
	localparam logic [7:0] HI_CALL1    = 8'hED;
	localparam logic [7:0] HI_LFSR     = 8'hEE;
	localparam logic [7:0] HI_TABLE    = 8'h00;
	localparam logic [3:0] TBL_RD_SEL  = 4'h0;
	localparam logic [3:0] TBL_WR_SEL  = 4'h1;
	localparam logic [3:0] SKIP_LO     = 4'h6; // f-skip ops 0x6x/bit-test
	localparam logic [7:0] HI_RETURN   = 8'h00;
	localparam logic [7:0] LO_RETURN_0 = 8'h12;
	localparam logic [7:0] LO_RETURN_1 = 8'h13;

	// ---------------------------------------------------------------
	// Sequencer timing
	// ---------------------------------------------------------------
	localparam logic [1:0] PHASE_LAST = 2'h3; // four clocks per cycle
	localparam logic [1:0] PHASE_ZERO = 2'h0;

	typedef enum logic [1:0] {
		PTR_KEEP     = 2'h0,
		PTR_POST_INC = 2'h1,
		PTR_POST_DEC = 2'h2,
		PTR_PRE_INC  = 2'h3
	} pointer_update_mode_type;

	typedef enum logic [1:0] {
		ST_FIRST  = 2'b00,
		ST_SECOND = 2'b01,
		ST_FLUSH  = 2'b11
	} seq_state_type;

	typedef struct packed {
		logic                        valid;
		logic                        is_nop;
		logic                        to_file;
		logic                        use_bank;
		logic [FILE_W-1:0]           file_addr;
		logic [BIT_W-1:0]            bit_num;
		logic [7:0]                  bit_mask;
		logic [LONG_FILE_W-1:0]      move_source_address;
		logic [LONG_FILE_W-1:0]      move_target_address;
		logic [LIT8_W-1:0]           lit8;
		logic [LIT12_W-1:0]          lit12;
		logic [LIT20_W-1:0]          lit20;
		logic                        fast_mode;
		logic                        relative;
		logic signed [BRANCH_W-1:0]  branch_offset;
		logic                        table_read;
		logic                        table_write;
		pointer_update_mode_type     pointer_update_mode;
	} decoded_type;

endpackage

// [core/instruction_field_decoder.sv]
// Contract
// - Most instructions are one 16-bit word; four take two words.
// - A second word has ones in top four bits; alone it is a no-op.
// - Single-word takes one cycle; skip or PC change adds a no-op cycle.
// - Two-word instructions take two instruction cycles; a redirect on the second word makes three.
// - One instruction cycle is four clock periods.
// - Destination bit zero goes to accumulator, one goes to file register.
// - Access bit zero uses access RAM; one uses bank select register.
// - Bit ops decode a three-bit bit number, 0 to 7.
// - Short file address is 8 bits, 0x00 to 0xFF.
// - Register move decodes 12-bit source and target addresses, no bank.
// - Literals come out as 8, 12 or 20 bits.
// - Table ops carry pointer mode: keep, post-inc, post-dec, pre-inc.
// - Fast bit on call/return saves or restores shadow registers.
// - Relative branches use signed offset; call/goto use direct address.
// - Table access uses 21-bit pointer and 8-bit table latch.
// - Bit ops decode file address, bit number and access bit.
// - Byte format: opcode 15:10, d bit 9, a bit 8, file 7:0.
// - Bit format: opcode 15:12, bit number 11:9, a bit 8, file 7:0.
// - Move second word is 1111 then 12-bit target address.
`timescale 1ns/1ns
`default_nettype none

module instruction_field_decoder
	import decode_pkg::*;
(
	input  wire logic                clock_i,        // 10 MHz clock
	input  wire logic                sys_rst_i,      // sync reset, high
	input  wire logic [WORD_W-1:0]   fetch_word_i,   // fetched program word
	input  wire logic                redirect_i,     // skip true or PC changed
	input  wire logic [7:0]          bank_select_register_i, // bank select
	input  wire logic [PTR_W-1:0]    program_memory_pointer_i, // table ptr
	output logic                     cycle_start_o,  // last clock of cycle
	output logic                     word_take_o,    // fetch word consumed
	output decoded_type              decoded_o,      // decoded controls
	output logic [LONG_FILE_W-1:0]   ram_address_o,  // banked RAM address
	output logic [PTR_W-1:0]         table_address_o,// table access address
	output logic [PTR_W-1:0]         pointer_next_o, // pointer after access
	output logic                     two_word_o,     // two-word in flight
	output logic [1:0]               cycles_o        // cycles of last instr
);

	// ---------------------------------------------------------------
	// Phase divider
	// ---------------------------------------------------------------
	logic [1:0] phase_q;
	wire        phase_end = (phase_q == PHASE_LAST);

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			phase_q <= PHASE_ZERO;
		end else begin
			phase_q <= phase_q + 2'h1;
		end
	end

	// ---------------------------------------------------------------
	// Field extraction
	// ---------------------------------------------------------------
	wire [3:0] top_nib = fetch_word_i[TOP_LSB +: 4];
	wire [7:0] hi_byte = fetch_word_i[15:8];
	wire [7:0] lo_byte = fetch_word_i[7:0];

	// Fields always come from fixed positions and are decoded for every word, so
	// don't-care bits still steer use_bank, to_file and the pointer mode.
	wire [FILE_W-1:0] file_fld = fetch_word_i[FILE_LSB +: FILE_W];
	wire              dest_fld = fetch_word_i[DEST_BIT];
	wire              acc_fld  = fetch_word_i[ACCESS_BIT];
	wire [BIT_W-1:0]  bit_fld  = fetch_word_i[BITNUM_LSB +: BIT_W];
	wire [LONG_FILE_W-1:0] long_fld = fetch_word_i[LONG_LSB +: LONG_FILE_W];

	wire is_second = (top_nib == TOP_SECOND);
	wire is_move   = (top_nib == TOP_MOVE);
	wire is_goto   = (hi_byte == HI_GOTO);
	wire is_call   = (hi_byte == HI_CALL0) || (hi_byte == HI_CALL1);
	wire is_lfsr   = (hi_byte == HI_LFSR);
	wire starts_two = is_move || is_goto || is_call || is_lfsr;
	wire is_bitop  = (top_nib >= TOP_BIT_LO) && (top_nib <= TOP_BIT_HI);
	wire is_rel    = (top_nib == TOP_BRA);
	wire is_table  = (hi_byte == HI_TABLE) && (lo_byte[7:4] == 4'h0)
		&& (lo_byte[3]);
	wire is_ret    = (hi_byte == HI_RETURN)
		&& ((lo_byte == LO_RETURN_0) || (lo_byte == LO_RETURN_1));
	wire [7:0] bit_mask_w = 8'h01 << bit_fld;

	// ---------------------------------------------------------------
	// Sequencer
	// ---------------------------------------------------------------
	seq_state_type state_q;
	seq_state_type state_d;
	decoded_type   dec_q;
	logic [WORD_W-1:0] first_q;
	logic [1:0]    cycles_q;
	logic          take_q;
	logic          start_q;
	logic          two_q;

	always_comb begin
		state_d = state_q;
		case (state_q)
			ST_FIRST: begin
				if (redirect_i) begin
					state_d = ST_FLUSH;
				end else if (starts_two) begin
					state_d = ST_SECOND;
				end
			end
			ST_SECOND: begin
				state_d = redirect_i ? ST_FLUSH : ST_FIRST;
			end
			ST_FLUSH: begin
				state_d = ST_FIRST;
			end
			default: begin
				state_d = ST_FIRST;
			end
		endcase
	end

	// Decode of the word in the first slot.
	decoded_type dec_first;
	always_comb begin
		dec_first = '0;
		dec_first.valid     = 1'b1;
		dec_first.is_nop    = is_second;
		dec_first.to_file   = dest_fld;
		dec_first.use_bank  = acc_fld;
		dec_first.file_addr = file_fld;
		dec_first.bit_num   = is_bitop ? bit_fld : '0;
		dec_first.bit_mask  = is_bitop ? bit_mask_w : 8'h00;
		dec_first.move_source_address = is_move ? long_fld : '0;
		dec_first.lit8      = lo_byte;
		dec_first.lit12     = long_fld;
		dec_first.fast_mode = (is_call || is_ret)
			&& fetch_word_i[FAST_BIT];
		dec_first.relative  = is_rel;
		dec_first.branch_offset = fetch_word_i[BRANCH_W-1:0];
		dec_first.table_read  = is_table && !lo_byte[2];
		dec_first.table_write = is_table && lo_byte[2];
		dec_first.pointer_update_mode = pointer_update_mode_type'(
			fetch_word_i[MODE_LSB +: MODE_W]);
	end

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			state_q  <= ST_FIRST;
			dec_q    <= '0;
			first_q  <= '0;
			cycles_q <= 2'h0;
			take_q   <= 1'b0;
			start_q  <= 1'b0;
			two_q    <= 1'b0;
		end else begin
			start_q <= (phase_q == PHASE_LAST - 2'h1);
			take_q  <= 1'b0;
			if (phase_end) begin
				state_q <= state_d;
				two_q   <= (state_d == ST_SECOND);
				take_q  <= 1'b1;
				case (state_q)
					ST_FIRST: begin
						first_q <= fetch_word_i;
						dec_q   <= dec_first;
						cycles_q <= (redirect_i || starts_two)
							? 2'h2 : 2'h1;
						if (starts_two) begin
							dec_q.valid <= 1'b0;
						end
					end
					ST_SECOND: begin
						dec_q.valid <= 1'b1;
						dec_q.move_target_address <= long_fld;
						dec_q.lit20 <= {long_fld,
							first_q[LIT8_W-1:0]};
						cycles_q <= redirect_i ? 2'h3 : 2'h2;
					end
					ST_FLUSH: begin
						dec_q <= '0;
						dec_q.valid  <= 1'b1;
						dec_q.is_nop <= 1'b1;
					end
					default: begin
						dec_q <= '0;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Address forming
	// ---------------------------------------------------------------
	logic [LONG_FILE_W-1:0] ram_q;
	logic [PTR_W-1:0]       tab_q;
	logic [PTR_W-1:0]       ptr_next_q;
	wire  [PTR_W-1:0]       ptr_inc = program_memory_pointer_i + 21'h1;
	wire  [PTR_W-1:0]       ptr_dec = program_memory_pointer_i - 21'h1;
	wire  [LONG_FILE_W-1:0] ram_w = dec_q.use_bank
		? {bank_select_register_i[3:0], dec_q.file_addr}
		: {{4{dec_q.file_addr[7]}}, dec_q.file_addr};

	always_ff @(posedge clock_i) begin
		if (sys_rst_i) begin
			ram_q      <= '0;
			tab_q      <= '0;
			ptr_next_q <= '0;
		end else begin
			ram_q <= ram_w;
			case (dec_q.pointer_update_mode)
				PTR_POST_INC: begin
					tab_q      <= program_memory_pointer_i;
					ptr_next_q <= ptr_inc;
				end
				PTR_POST_DEC: begin
					tab_q      <= program_memory_pointer_i;
					ptr_next_q <= ptr_dec;
				end
				PTR_PRE_INC: begin
					tab_q      <= ptr_inc;
					ptr_next_q <= ptr_inc;
				end
				default: begin
					tab_q      <= program_memory_pointer_i;
					ptr_next_q <= program_memory_pointer_i;
				end
			endcase
		end
	end

	assign cycle_start_o   = start_q;
	assign word_take_o     = take_q;
	assign decoded_o       = dec_q;
	assign ram_address_o   = ram_q;
	assign table_address_o = tab_q;
	assign pointer_next_o  = ptr_next_q;
	assign two_word_o      = two_q;
	assign cycles_o        = cycles_q;

endmodule

`default_nettype wire

// [verif/decoder_props.sv]
`timescale 1ns/1ns
`default_nettype none
module decoder_props
	import decode_pkg::*;
(
	input wire logic                   clock_i,
	input wire logic                   sys_rst_i,
	input wire logic [WORD_W-1:0]      fetch_word_i,
	input wire logic                   redirect_i,
	input wire logic [7:0]             bank_select_register_i,
	input wire logic                   cycle_start_o,
	input wire logic                   word_take_o,
	input wire decoded_type            decoded_o,
	input wire logic [LONG_FILE_W-1:0] ram_address_o,
	input wire logic                   two_word_o,
	input wire logic [1:0]             cycles_o
);
	// ---------------------------------------------------------------
	// Sampled history
	// ---------------------------------------------------------------
	// The word, state and redirect stand for three clocks or more before the
	// sample edge, so the two-deep history still lines up with the take.
	logic [WORD_W-1:0] w1_q, w2_q;
	logic              tw1_q, tw2_q, r1_q, r2_q;
	always_ff @(posedge clock_i) begin
		w1_q  <= fetch_word_i;
		w2_q  <= w1_q;
		tw1_q <= two_word_o;
		tw2_q <= tw1_q;
		r1_q  <= redirect_i;
		r2_q  <= r1_q;
	end
	wire logic take    = word_take_o && !tw2_q && !decoded_o.is_nop;
	wire logic byte_op = w2_q[15:12] >= 4'h1 && w2_q[15:12] <= 4'h5;
	wire logic bit_op  = w2_q[15:12] >= TOP_BIT_LO && w2_q[15:12] <= TOP_BIT_HI;
	wire logic lone    = word_take_o && !tw2_q && w2_q[15:12] == TOP_SECOND;
	// ---------------------------------------------------------------
	// Properties
	// ---------------------------------------------------------------
	default clocking @(posedge clock_i); endclocking
	default disable iff (sys_rst_i);
	sequence gap_s;
		!cycle_start_o [*3] ##1 cycle_start_o;
	endsequence
	phase_period_a: assert property (cycle_start_o |=> gap_s)
		else $error("cycle start spacing wrong");
	byte_fields_a: assert property (take && byte_op |->
		{decoded_o.to_file, decoded_o.use_bank, decoded_o.file_addr}
		== w2_q[9:0]) else $error("byte operand fields wrong");
	bit_fields_a: assert property (take && bit_op |->
		{decoded_o.bit_num, decoded_o.use_bank, decoded_o.file_addr}
		== w2_q[11:0] && decoded_o.bit_mask == 8'h01 << w2_q[11:9])
		else $error("bit operand fields wrong");
	bank_map_a: assert property (take && (byte_op || bit_op) |=>
		ram_address_o == (decoded_o.use_bank ?
		{$past(bank_select_register_i[3:0]), decoded_o.file_addr} :
		{{4{decoded_o.file_addr[7]}}, decoded_o.file_addr}))
		else $error("ram address mapping wrong");
	lone_nop_a: assert property (lone |-> decoded_o.is_nop)
		else $error("lone second word not a no-op");
	one_cycle_a: assert property (take && byte_op && !r2_q |->
		cycles_o == 2'h1) else $error("single word cycle count wrong");
	two_cycle_a: assert property (word_take_o && tw2_q |->
		cycles_o == 2'h2 && decoded_o.valid)
		else $error("two word cycle count wrong");
	first_half_a: assert property (word_take_o && !tw2_q && two_word_o
		|-> !decoded_o.valid) else $error("first half marked valid");
	flush_nop_a: assert property (word_take_o && r2_q |->
		##4 decoded_o.is_nop) else $error("word after redirect not flushed");
endmodule
`default_nettype wire

// [verif/program_memory_model.sv]
`timescale 1ns/1ns
`default_nettype none
module program_memory_model
	import decode_pkg::*;
(
	input  wire logic              clock_i,      // system clock
	input  wire logic              load_i,       // new word offered
	input  wire logic [WORD_W-1:0] word_i,       // word to present
	input  wire logic              word_take_i,  // decoder took the word
	output var  logic [WORD_W-1:0] fetch_word_o  // fetch bus
);
	// A taken word is not held; the bus shows its inverse afterwards.
	initial fetch_word_o = 16'h0000;
	always @(posedge clock_i) begin
		if (load_i) begin
			fetch_word_o <= word_i;
		end else if (word_take_i) begin
			fetch_word_o <= ~fetch_word_o;
		end
	end
endmodule
`default_nettype wire

// [verif/tb_top.sv]
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import decode_pkg::*;
	logic clock_i = 1'b0, sys_rst_i = 1'b1, redirect_i = 1'b0, load = 1'b0;
	logic [15:0] word = 16'h0000;
	logic [7:0] bank = 8'h00, pb = 8'h00;
	logic [PTR_W-1:0] ptr = 21'h000000, pv = 21'h000000;
	wire logic [15:0] fetch;
	wire logic cyc_start, take, two_word;
	wire decoded_type dec;
	wire logic [11:0] ram_addr;
	wire logic [PTR_W-1:0] tab_addr, ptr_next;
	wire logic [1:0] cycles;
	int bad_count = 0, tests_run = 0, seed = 9, i;
	instruction_field_decoder u_instruction_field_decoder (
		.clock_i(clock_i), .sys_rst_i(sys_rst_i), .fetch_word_i(fetch),
		.redirect_i(redirect_i), .bank_select_register_i(bank),
		.program_memory_pointer_i(ptr), .cycle_start_o(cyc_start),
		.word_take_o(take), .decoded_o(dec), .ram_address_o(ram_addr),
		.table_address_o(tab_addr), .pointer_next_o(ptr_next),
		.two_word_o(two_word), .cycles_o(cycles));
	program_memory_model u_program_memory_model (.clock_i(clock_i),
		.load_i(load), .word_i(word), .word_take_i(take),
		.fetch_word_o(fetch));
	initial forever #50 clock_i = ~clock_i;
	task automatic end_of_test;
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Offers one word just after the previous one was taken, so it is
	// settled on the fetch bus well before the next sample edge.
	task automatic step(input logic [15:0] w, input logic r);
		int n;
		n = 0;
		@(negedge clock_i);
		while (take !== 1'b1 && n < 20) begin
			n++;
			@(negedge clock_i);
		end
		word = w;
		load = 1'b1;
		redirect_i = r;
		bank = 8'($random(seed));
		ptr = PTR_W'($random(seed));
		pb = bank;
		pv = ptr;
		@(negedge clock_i);
		load = 1'b0;
	endtask
	function automatic logic [PTR_W-1:0] nxt(input logic [1:0] m,
		input logic [PTR_W-1:0] p);
		return m == 2'h0 ? p : m == 2'h2 ? p - 21'h000001 : p + 21'h000001;
	endfunction
	function automatic logic [11:0] ram(input logic [7:0] b,
		input logic [7:0] f, input logic u);
		return u ? {b[3:0], f} : {{4{f[7]}}, f};
	endfunction
	initial begin
		#1000000;
		bad_count++;
		end_of_test();
	end
	initial begin
		logic [31:0] a;
		logic [15:0] w;
		logic [7:0] h;
		repeat (6) @(negedge clock_i);
		sys_rst_i = 1'b0;
		for (i = 0; i < 160; i++) begin
			a = $random(seed);
			w = a[15:0];
			case (a[31:29])
				3'd0, 3'd1: begin
					w[15:12] = 4'h1 + {2'b00, a[13:12]};
					step(w, a[20]);
					if (a[20]) step(w, 1'b0);
					step(16'h0000, 1'b0);
					if (a[20]) check(dec.is_nop, 1);
					else begin
						check({dec.to_file, dec.use_bank, dec.file_addr}, w[9:0]);
						check(ram_addr, ram(pb, w[7:0], w[8]));
					end
				end
				3'd2: begin
					w[15:12] = TOP_BIT_LO + {2'b00, a[13:12]};
					step(w, 1'b0);
					step(16'h0000, 1'b0);
					check({dec.bit_num, dec.use_bank, dec.file_addr}, w[11:0]);
					check(dec.bit_mask, 8'h01 << w[11:9]);
				end
				3'd3: begin
					w = 16'h0008 | {13'h0000, a[2:0]};
					step(w, 1'b0);
					step(16'h0000, 1'b0);
					check(dec.pointer_update_mode, w[1:0]);
					check(ptr_next, nxt(w[1:0], pv));
					check(tab_addr, w[1:0] == 2'h3 ? pv + 21'h000001 : pv);
					check(dec.table_read ^ dec.table_write, 1);
				end
				3'd4: begin
					step({TOP_MOVE, a[11:0]}, 1'b0);
					step({TOP_SECOND, a[27:16]}, 1'b0);
					step(16'h0000, 1'b0);
					check({dec.move_source_address, dec.move_target_address}, {a[11:0], a[27:16]});
				end
				3'd5: begin
					h = a[1] ? HI_GOTO : a[0] ? HI_CALL1 : HI_CALL0;
					step({h, a[15:8]}, 1'b0);
					step({TOP_SECOND, a[27:16]}, 1'b0);
					step(16'h0000, 1'b0);
					if (a[1]) check(dec.lit20, {a[27:16], a[15:8]});
					else check(dec.fast_mode, a[8]);
				end
				3'd6: begin
					w = a[3] ? {TOP_BRA, a[11:0]} : {8'h00, 7'h09, a[0]};
					step(w, 1'b0);
					step(16'h0000, 1'b0);
					if (a[3]) check({dec.relative, dec.branch_offset}, {1'b1, w[10:0]});
					else check(dec.fast_mode, w[0]);
				end
				default: begin
					step({TOP_SECOND, a[11:0]}, 1'b0);
					step(16'h0000, 1'b0);
					check(dec.is_nop, 1);
				end
			endcase
		end
		end_of_test();
	end
endmodule
bind instruction_field_decoder decoder_props u_decoder_props (
	.clock_i(clock_i), .sys_rst_i(sys_rst_i), .fetch_word_i(fetch_word_i),
	.redirect_i(redirect_i),
	.bank_select_register_i(bank_select_register_i),
	.cycle_start_o(cycle_start_o), .word_take_o(word_take_o),
	.decoded_o(decoded_o), .ram_address_o(ram_address_o),
	.two_word_o(two_word_o), .cycles_o(cycles_o));
`default_nettype wire
